// ==== logic/mdlk_dev.sv ====
// device end: management frame slave with latching status bits
`timescale 1ns/1ps
module mdlk_dev
   import mdlk_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   mdlk_if.device MDIO,
   input wire logic [4:0] PHY_ADDR,
   input wire logic [STRAP_W-1:0] STRAP_PINS,
   input wire logic LINK_UP,
   input wire logic PAGE_RX_EVT,
   input wire logic FAULT_EVT,
   output logic REF_CLOCK_OUT,
   output logic [STRAP_W-1:0] CFG_STRAP,
   output logic ABORT_PULSE,
   output logic [1:0] SEL_MMD,
   output logic SEL_VENDOR
);
   typedef enum logic [4:0] {
      D_IDLE = 5'b00001,
      D_HDR = 5'b00010,
      D_TA = 5'b00100,
      D_RD = 5'b01000,
      D_WR = 5'b10000
   } mdlk_dst_t;
   mdlk_dst_t st_r;
   logic mdc_q_r;
   logic [5:0] cnt_r;
   logic [13:0] hdr_r;
   logic [15:0] sh_r;
   logic dout_r;
   logic doe_r;
   logic [4:0] mmd_r;
   logic [15:0] addr_r;
   logic [15:0] ctrl_r;
   logic [STRAP_W-1:0] strap_r;
   logic link_seen_r;
   logic link_lat_r;
   logic page_lat_r;
   logic fault_lat_r;
   logic refclk_r;
   logic [7:0] ref_div_r;
   logic rise;
   logic fall;
   logic me;
   logic c45;
   logic hit_stat;
   logic [15:0] stat_val;
   assign rise = MDIO.mdc && !mdc_q_r;
   assign fall = !MDIO.mdc && mdc_q_r;
   assign c45 = (hdr_r[13:12] == ST_C45);
   assign me = (hdr_r[9:5] == PHY_ADDR);
   // status register reached at clause 22 index 1 or the autoneg device at register 0x0201
   assign hit_stat = c45 ? (mmd_r == C45_AN_DEV && addr_r == C45_AN_STAT_REG) : (hdr_r[4:0] == C22_STAT_REG);
   always_comb begin
      stat_val = STAT_RESET;
      stat_val[LINK_BIT] = LINK_UP && !link_lat_r;
      stat_val[PAGE_BIT] = page_lat_r;
      stat_val[FAULT_BIT] = fault_lat_r;
   end
   assign MDIO.mdio_dev_o = dout_r;
   assign MDIO.mdio_dev_oe = doe_r;
   assign SEL_MMD = mmd_r[1:0];
   assign SEL_VENDOR = (addr_r >= VEND_FIRST);
   assign CFG_STRAP = strap_r;
   // refclk derived from sys clock; held low through reset
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         refclk_r <= 1'b0;
         ref_div_r <= 8'h00;
      end else if (REF_DIV <= 1) begin
         refclk_r <= 1'b1;
         ref_div_r <= 8'h00;
      end else if (ref_div_r == 8'(REF_DIV / 2 - 1)) begin
         refclk_r <= !refclk_r;
         ref_div_r <= 8'h00;
      end else begin
         ref_div_r <= ref_div_r + 8'h01;
      end
   end
   // at divide-by-one the pass-through gates the system clock itself
   assign REF_CLOCK_OUT = (REF_DIV <= 1) ? (SYS_CLK & refclk_r) : refclk_r;
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         mdc_q_r <= 1'b0;
      else
         mdc_q_r <= MDIO.mdc;
   end
   // strap caught while in reset, not on the async path
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         strap_r <= STRAP_PINS;
   end
   // latching flags: event set wins over read clear
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         link_seen_r <= 1'b0;
         link_lat_r <= 1'b0;
         page_lat_r <= 1'b0;
         fault_lat_r <= 1'b0;
      end else begin
         if (LINK_UP)
            link_seen_r <= 1'b1;
         if (link_seen_r && !LINK_UP)
            link_lat_r <= 1'b1;
         else if (st_r == D_RD && cnt_r == 6'd1 && fall && hit_stat)
            link_lat_r <= 1'b0;
         if (PAGE_RX_EVT)
            page_lat_r <= 1'b1;
         else if (st_r == D_RD && cnt_r == 6'd1 && fall && hit_stat)
            page_lat_r <= 1'b0;
         if (FAULT_EVT)
            fault_lat_r <= 1'b1;
         else if (st_r == D_RD && cnt_r == 6'd1 && fall && hit_stat)
            fault_lat_r <= 1'b0;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      ABORT_PULSE <= 1'b0;
      if (RST) begin
         st_r <= D_IDLE;
         cnt_r <= 6'h00;
         hdr_r <= 14'h0000;
         sh_r <= 16'h0000;
         dout_r <= 1'b1;
         doe_r <= 1'b0;
         mmd_r <= 5'h00;
         addr_r <= 16'h0000;
         ctrl_r <= CTRL_RESET;
      end else begin
         unique case (st_r)
            // a zero after the ones of the preamble is the first start bit
            D_IDLE: if (rise && !MDIO.mdio_i) begin
               hdr_r <= 14'h0000;
               cnt_r <= 6'd13;
               st_r <= D_HDR;
            end
            D_HDR: if (rise) begin
               hdr_r <= {hdr_r[12:0], MDIO.mdio_i};
               if (cnt_r == 6'd1) begin
                  cnt_r <= 6'd2;
                  st_r <= D_TA;
               end else begin
                  cnt_r <= cnt_r - 6'h1;
               end
            end
            D_TA: begin
               // drive only the second turnaround bit; the first stays released
               if (fall && cnt_r == 6'd1 && me && hdr_r[11] && (c45 || hdr_r[10] == 1'b0)) begin
                  doe_r <= 1'b1;
                  dout_r <= 1'b0;
                  sh_r <= (hit_stat || !c45 && hdr_r[4:0] == 5'h00) ? (hit_stat ? stat_val : ctrl_r) : 16'h0000;
               end
               if (rise) begin
                  cnt_r <= cnt_r - 6'h1;
                  if (cnt_r == 6'd1) begin
                     cnt_r <= 6'd16;
                     st_r <= (hdr_r[11] && (c45 || !hdr_r[10])) ? D_RD : D_WR;
                     if (c45 && me)
                        mmd_r <= hdr_r[4:0];
                  end
               end
            end
            D_RD: if (fall) begin
               if (!me) begin
                  st_r <= D_IDLE;
               end else if (cnt_r == 6'd0) begin
                  doe_r <= 1'b0;
                  st_r <= D_IDLE;
                  // op 10 is the post-read-increment read
                  if (c45 && !hdr_r[10])
                     addr_r <= addr_r + 16'h0001;
               end else begin
                  dout_r <= sh_r[15];
                  sh_r <= {sh_r[14:0], 1'b0};
                  cnt_r <= cnt_r - 6'h1;
               end
            end
            D_WR: if (rise) begin
               sh_r <= {sh_r[14:0], MDIO.mdio_i};
               cnt_r <= cnt_r - 6'h1;
               if (cnt_r == 6'd1) begin
                  st_r <= D_IDLE;
                  if (me && c45 && hdr_r[11:10] == OP_ADDR)
                     addr_r <= {sh_r[14:0], MDIO.mdio_i};
                  else if (me && hdr_r[11:10] == OP_WRITE &&
                           (c45 ? addr_r == 16'h0000 && mmd_r == 5'h01 : hdr_r[4:0] == 5'h00)) begin
                     ctrl_r <= {sh_r[14:0], MDIO.mdio_i};
                     ctrl_r[ABORT_BIT] <= 1'b0;
                     ABORT_PULSE <= MDIO.mdio_i;
                  end
               end
            end
            default: st_r <= D_IDLE;
         endcase
      end
   end
endmodule // mdlk_dev

// ==== logic/mdlk_host.sv ====
// host end: runs clause 22 and clause 45 frames on command
`timescale 1ns/1ps
module mdlk_host
   import mdlk_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   mdlk_if.host MDIO,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_C45,
   input wire logic [1:0] CMD_OP,
   input wire logic [4:0] CMD_PHY,
   input wire logic [4:0] CMD_DEV,
   input wire logic [15:0] CMD_ADDR,
   input wire logic [15:0] CMD_WDATA,
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_PRE = 4'b0010,
      H_FRAME = 4'b0100,
      H_DONE = 4'b1000
   } mdlk_hst_t;
   mdlk_hst_t st_r;
   logic [1:0] div_r;
   logic mdc_r;
   logic [5:0] cnt_r;
   logic [31:0] sh_r;
   logic [15:0] rd_r;
   logic rd_frame_r;
   logic second_r;
   logic c45_r;
   logic [1:0] op_r;
   logic [4:0] phy_r;
   logic [4:0] dev_r;
   logic [15:0] wdata_r;
   logic rise;
   logic fall;
   assign rise = (div_r == 2'(MDC_HALF - 1)) && !mdc_r;
   assign fall = (div_r == 2'(MDC_HALF - 1)) && mdc_r;
   assign CMD_READY = (st_r == H_IDLE);
   assign MDIO.mdc = mdc_r;
   // preamble ones come from the state; the shifter already holds the frame
   assign MDIO.mdio_host_o = (st_r == H_PRE) ? 1'b1 : sh_r[31];
   // release the wire for both turnaround bits and data on reads
   assign MDIO.mdio_host_oe = (st_r == H_PRE) || (st_r == H_FRAME && !(rd_frame_r && cnt_r < 6'd19));
   always_ff @(posedge SYS_CLK) begin
      if (RST || st_r == H_IDLE) begin
         div_r <= 2'h0;
         mdc_r <= 1'b0;
      end else if (div_r == 2'(MDC_HALF - 1)) begin
         div_r <= 2'h0;
         mdc_r <= !mdc_r;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end
   // a clause 45 read or write is an address frame then the operation frame
   function automatic logic [31:0] build(input logic c45, input logic [1:0] op, input logic [4:0] ph,
                                         input logic [4:0] rg, input logic [15:0] d);
      build = {c45 ? ST_C45 : ST_C22, op, ph, rg, TA_WRITE, d};
   endfunction
   always_ff @(posedge SYS_CLK) begin
      RSP_VALID <= 1'b0;
      if (RST) begin
         st_r <= H_IDLE;
         cnt_r <= 6'h00;
         sh_r <= 32'hffff_ffff;
         rd_r <= 16'h0000;
         rd_frame_r <= 1'b0;
         second_r <= 1'b0;
         c45_r <= 1'b0;
         op_r <= 2'h0;
         phy_r <= 5'h00;
         dev_r <= 5'h00;
         wdata_r <= 16'h0000;
         RSP_RDATA <= 16'h0000;
      end else begin
         unique case (st_r)
            H_IDLE: if (CMD_VALID) begin
               c45_r <= CMD_C45;
               op_r <= CMD_OP;
               phy_r <= CMD_PHY;
               dev_r <= CMD_DEV;
               wdata_r <= CMD_WDATA;
               // an address-only command is a single frame
               second_r <= !CMD_C45 || CMD_OP == OP_ADDR;
               rd_frame_r <= 1'b0;
               if (CMD_C45)
                  sh_r <= build(1'b1, OP_ADDR, CMD_PHY, CMD_DEV, CMD_ADDR);
               else
                  sh_r <= build(1'b0, CMD_OP, CMD_PHY, CMD_ADDR[4:0], CMD_WDATA);
               cnt_r <= 6'(PRE_BITS);
               st_r <= H_PRE;
            end
            H_PRE: if (fall) begin
               if (cnt_r == 6'd1) begin
                  cnt_r <= 6'(FRAME_BITS);
                  rd_frame_r <= second_r && op_r[1] && (c45_r || op_r == OP_READ);
                  st_r <= H_FRAME;
               end else begin
                  cnt_r <= cnt_r - 6'h1;
               end
            end
            H_FRAME: begin
               if (rise && rd_frame_r && cnt_r <= 6'd16)
                  rd_r <= {rd_r[14:0], MDIO.mdio_i};
               if (fall) begin
                  sh_r <= {sh_r[30:0], 1'b1};
                  if (cnt_r == 6'd1) begin
                     if (!second_r) begin
                        second_r <= 1'b1;
                        // clause 45 wire codes: plain read 11, post-increment read 10
                        sh_r <= build(1'b1, op_r[1] ? {1'b1, !op_r[0]} : op_r, phy_r, dev_r, wdata_r);
                        cnt_r <= 6'(PRE_BITS);
                        st_r <= H_PRE;
                     end else begin
                        st_r <= H_DONE;
                     end
                  end else begin
                     cnt_r <= cnt_r - 6'h1;
                  end
               end
            end
            H_DONE: begin
               RSP_VALID <= 1'b1;
               RSP_RDATA <= rd_r;
               st_r <= H_IDLE;
            end
         endcase
      end
   end
endmodule // mdlk_host

// ==== logic/mdlk_if.sv ====
// interface: management clock and data wire between host and device
`timescale 1ns/1ps
interface mdlk_if;
   logic mdc;
   logic mdio_host_o;
   logic mdio_host_oe;
   logic mdio_dev_o;
   logic mdio_dev_oe;
   logic mdio_i;
   assign mdio_i = mdio_dev_oe ? mdio_dev_o : (mdio_host_oe ? mdio_host_o : 1'b1);
   modport device (input mdc, input mdio_i, output mdio_dev_o, output mdio_dev_oe);
   modport host (output mdc, input mdio_i, output mdio_host_o, output mdio_host_oe);
endinterface

// ==== logic/mdlk_pkg.sv ====
// package: frame fields, opcodes, address constants and clock figures
package mdlk_pkg;
   localparam int SYS_CLK_HZ = 25000000;
   localparam int REF_CLK_HZ = 25000000;
   localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
   localparam int PRE_BITS = 32;
   localparam int FRAME_BITS = 32;
   localparam logic [1:0] ST_C22 = 2'b01;
   localparam logic [1:0] ST_C45 = 2'b00;
   localparam logic [1:0] OP_ADDR = 2'b00;
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] OP_RDINC = 2'b11;
   localparam logic [1:0] TA_WRITE = 2'b10;
   localparam int NUM_MMD = 4;
   localparam logic [15:0] STD_LAST = 16'h7fff;
   localparam logic [15:0] VEND_FIRST = 16'h8000;
   localparam logic [4:0] C22_STAT_REG = 5'h01;
   localparam logic [4:0] C45_AN_DEV = 5'h07;
   localparam logic [15:0] C45_AN_STAT_REG = 16'h0201;
   localparam int LINK_BIT = 2;
   localparam int PAGE_BIT = 6;
   localparam int FAULT_BIT = 4;
   localparam int ABORT_BIT = 0;
   localparam logic [15:0] STAT_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam int STRAP_W = 4;
   localparam int MDC_HALF = 2;
endpackage

// ==== tb/mdlk_checker.sv ====
// checker: drive and timing relations on the management wire
`timescale 1ns/1ps
module mdlk_checker
   import mdlk_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic mdc,
   input wire logic mdio_host_o,
   input wire logic mdio_host_oe,
   input wire logic mdio_dev_o,
   input wire logic mdio_dev_oe,
   input wire logic mdio_i
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   logic [9:0] hrun_r;
   logic [9:0] drun_r;
   // drive run lengths; a short or long run means a bit was lost or added
   always_ff @(posedge SYS_CLK) begin
      if (RST || !mdio_host_oe) begin
         hrun_r <= 10'h000;
      end else begin
         hrun_r <= hrun_r + 10'h001;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (RST || !mdio_dev_oe) begin
         drun_r <= 10'h000;
      end else begin
         drun_r <= drun_r + 10'h001;
      end
   end
   a_quiet_after_reset: assert property ($fell(RST) |-> !mdio_host_oe && !mdio_dev_oe) else $error("wire driven at reset exit");
   a_one_driver: assert property (!(mdio_host_oe && mdio_dev_oe)) else $error("both ends drive the wire");
   a_idle_high: assert property (!mdio_host_oe && !mdio_dev_oe |-> mdio_i) else $error("released wire not high");
   a_mdc_half: assert property ($changed(mdc) |=> $stable(mdc)) else $error("clock level shorter than two cycles");
   a_host_setup: assert property (mdio_host_oe && $past(mdio_host_oe) && $changed(mdio_host_o) |-> !mdc)
      else $error("host data moved while clock high");
   a_pre_ones: assert property ($rose(mdio_host_oe) |-> mdio_host_o) else $error("frame not opened by preamble");
   a_ta_zero: assert property ($rose(mdio_dev_oe) |-> !mdio_dev_o && !$past(mdio_host_oe))
      else $error("device turnaround wrong");
   a_host_len: assert property ($fell(mdio_host_oe) |-> hrun_r inside {[10'h0b4:10'h0bc], [10'h0fc:10'h104],
      [10'h1b4:10'h1bc], [10'h1fc:10'h204]})
      else $error("host drive length wrong");
   a_dev_len: assert property ($fell(mdio_dev_oe) |-> drun_r inside {[10'h03e:10'h046]})
      else $error("device drive length wrong");
   c_read: cover property ($rose(mdio_dev_oe));
   c_long: cover property ($fell(mdio_host_oe) && hrun_r > 10'h0f0);
   c_short: cover property ($fell(mdio_host_oe) && hrun_r < 10'h0c0);
   c_c45_read: cover property ($fell(mdio_host_oe) && hrun_r > 10'h1b0 && hrun_r < 10'h1c0);
endmodule // mdlk_checker

// ==== tb/test_mdio_mgmt_latch_low.sv ====
// testbench: host and device ends joined, latches and decode checked
`timescale 1ns/1ps
module test_mdio_mgmt_latch_low
   import mdlk_pkg::*;
;
   logic sys_clk, rst, cmd_valid, cmd_c45, link_up, page_evt, fault_evt;
   logic [1:0] cmd_op;
   logic [4:0] cmd_phy, cmd_dev, phy_addr;
   logic [15:0] cmd_addr, cmd_wdata, rsp_rdata;
   logic [STRAP_W-1:0] strap_pins, strap_exp, cfg_strap;
   logic cmd_ready, rsp_valid, ref_clk, abort_pulse, sel_vendor;
   logic [1:0] sel_mmd;
   logic [31:0] exp_q[$];
   logic [31:0] e;
   int fail_count, n_checks, cycles, aborts;
   localparam logic [15:0] lm = 16'h0001 << LINK_BIT;
   localparam logic [15:0] pm = 16'h0001 << PAGE_BIT;
   localparam logic [15:0] fm = 16'h0001 << FAULT_BIT;
   localparam logic [15:0] va [4] = '{VEND_FIRST, STD_LAST, 16'hffff, 16'h0000};
   mdlk_if link_if();
   mdlk_host mdlk_host_inst(.SYS_CLK(sys_clk), .RST(rst), .MDIO(link_if.host), .CMD_VALID(cmd_valid),
      .CMD_READY(cmd_ready), .CMD_C45(cmd_c45), .CMD_OP(cmd_op), .CMD_PHY(cmd_phy), .CMD_DEV(cmd_dev),
      .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
   mdlk_dev mdlk_dev_inst(.SYS_CLK(sys_clk), .RST(rst), .MDIO(link_if.device), .PHY_ADDR(phy_addr),
      .STRAP_PINS(strap_pins), .LINK_UP(link_up), .PAGE_RX_EVT(page_evt), .FAULT_EVT(fault_evt),
      .REF_CLOCK_OUT(ref_clk), .CFG_STRAP(cfg_strap), .ABORT_PULSE(abort_pulse), .SEL_MMD(sel_mmd),
      .SEL_VENDOR(sel_vendor));
   mdlk_checker mdlk_checker_inst(.SYS_CLK(sys_clk), .RST(rst), .mdc(link_if.mdc),
      .mdio_host_o(link_if.mdio_host_o), .mdio_host_oe(link_if.mdio_host_oe), .mdio_dev_o(link_if.mdio_dev_o),
      .mdio_dev_oe(link_if.mdio_dev_oe), .mdio_i(link_if.mdio_i));
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] want, input logic [15:0] msk);
      n_checks++;
      if ((got & msk) !== (want & msk)) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // request held from a falling edge until a rising edge sees ready
   task automatic cmd(input logic c45, input logic [1:0] op, input logic [4:0] phy, input logic [4:0] dev,
         input logic [15:0] adr, input logic [15:0] wd);
      int n;
      @(negedge sys_clk);
      cmd_c45 = c45;
      cmd_op = op;
      cmd_phy = phy;
      cmd_dev = dev;
      cmd_addr = adr;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 1500) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 1500) begin
         fail_count++;
         print_verdict();
      end
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic rd(input logic c45, input logic [4:0] phy, input logic [4:0] dev, input logic [15:0] adr,
         input logic [15:0] want, input logic [15:0] msk);
      exp_q.push_back({msk, want});
      cmd(c45, OP_READ, phy, dev, adr, 16'h0000);
   endtask
   task automatic st(input logic c45, input logic [15:0] want, input logic [15:0] msk);
      if (c45) begin
         rd(1'b1, phy_addr, C45_AN_DEV, C45_AN_STAT_REG, want, msk);
      end else begin
         rd(1'b0, phy_addr, 5'h00, {11'h000, C22_STAT_REG}, want, msk);
      end
   endtask
   task automatic drop_link();
      @(negedge sys_clk);
      link_up = 1'b0;
      repeat (4) @(negedge sys_clk);
      link_up = 1'b1;
   endtask
   // mid-cycle sampling: one-cycle outputs are seen once, with no edge race
   always @(negedge sys_clk) begin
      if (abort_pulse === 1'b1) aborts++;
      if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         chk(rsp_rdata, e[15:0], e[31:16]);
      end
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      logic [15:0] wd;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_c45 = 1'b0;
      cmd_op = OP_READ;
      cmd_phy = 5'h00;
      cmd_dev = 5'h00;
      cmd_addr = 16'h0000;
      cmd_wdata = 16'h0000;
      link_up = 1'b1;
      page_evt = 1'b0;
      fault_evt = 1'b0;
      void'($urandom(94892));
      phy_addr = 5'($urandom);
      strap_pins = STRAP_W'($urandom);
      strap_exp = strap_pins;
      repeat (6) @(posedge sys_clk);
      #10;
      chk(16'(ref_clk), 16'h0000, 16'h0001);
      @(negedge sys_clk);
      rst = 1'b0;
      strap_pins = ~strap_exp;
      repeat (2) @(posedge sys_clk);
      #10;
      chk(16'(ref_clk), 16'h0001, 16'h0001);
      chk(16'(cfg_strap), 16'(strap_exp), 16'hffff);
      #20;
      chk(16'(ref_clk), 16'h0000, 16'h0001);
      st(1'b0, lm, lm);
      drop_link();
      st(1'b0, 16'h0000, lm);
      st(1'b0, lm, lm);
      drop_link();
      st(1'b1, 16'h0000, lm);
      st(1'b1, lm, lm);
      drop_link();
      @(negedge sys_clk);
      page_evt = 1'b1;
      fault_evt = 1'b1;
      @(negedge sys_clk);
      page_evt = 1'b0;
      fault_evt = 1'b0;
      st(1'b1, pm | fm, lm | pm | fm);
      st(1'b0, lm, lm | pm | fm);
      link_up = 1'b0;
      st(1'b0, 16'h0000, lm);
      st(1'b0, 16'h0000, lm);
      link_up = 1'b1;
      st(1'b0, 16'h0000, lm);
      st(1'b0, lm, lm);
      cmd(1'b0, OP_WRITE, phy_addr, 5'h00, {11'h000, C22_STAT_REG}, 16'h0000);
      st(1'b0, lm, lm);
      rd(1'b0, ~phy_addr, 5'h00, {11'h000, C22_STAT_REG}, 16'hffff, 16'hffff);
      rd(1'b1, ~phy_addr, C45_AN_DEV, C45_AN_STAT_REG, 16'hffff, 16'hffff);
      foreach (va[i]) begin
         cmd(1'b1, OP_ADDR, phy_addr, C45_AN_DEV, va[i], 16'h0000);
         chk(16'(sel_vendor), 16'(va[i] >= VEND_FIRST), 16'h0001);
         chk(16'(sel_mmd), 16'(C45_AN_DEV[1:0]), 16'h0003);
      end
      aborts = 0;
      wd = 16'($urandom);
      cmd(1'b0, OP_WRITE, phy_addr, 5'h00, 16'h0000, wd | 16'h0001);
      rd(1'b0, phy_addr, 5'h00, 16'h0000, wd & 16'hfffe, 16'hffff);
      cmd(1'b1, OP_WRITE, phy_addr, 5'h01, 16'h0000, 16'h0001);
      cmd(1'b0, OP_WRITE, ~phy_addr, 5'h00, 16'h0000, 16'h0001);
      cmd(1'b0, OP_WRITE, phy_addr, 5'h00, 16'h0000, wd & 16'hfffe);
      rd(1'b0, phy_addr, 5'h00, 16'h0000, wd & 16'hfffe, 16'hffff);
      chk(16'(aborts), 16'h0002, 16'hffff);
      chk(16'(cfg_strap), 16'(strap_exp), 16'hffff);
      chk(16'(exp_q.size()), 16'h0000, 16'hffff);
      print_verdict();
   end
endmodule // test_mdio_mgmt_latch_low
